// file: period_timer_asserts.sv
// assertions on the period timer's bus handshakes and peripheral outputs
// bound into period_timer_with_limit; one aclk domain, synchronous reset
`timescale 1ns/10ps
`include "period_timer_regs.vh"
module period_timer_asserts (
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // write channels
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    // read channels
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // peripheral outputs
    input wire        postscaled_pulse,
    input wire        period_match,
    input wire        timer_irq_flag
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst_quiet; $rose(aresetn) |-> !(s_axi_bvalid | s_axi_rvalid | postscaled_pulse
        | period_match | timer_irq_flag); endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output high after reset");
    property p_wr_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid; endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read data late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_ar_refused; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_refused: assert property (p_ar_refused) else $error("read taken while busy");
    property p_err_zero; s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    property p_flag_set; $rose(postscaled_pulse) |-> ##[0:2] timer_irq_flag; endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set by pulse");
endmodule // period_timer_asserts

bind period_timer_with_limit period_timer_asserts u_period_timer_asserts (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .postscaled_pulse, .period_match, .timer_irq_flag);

// file: period_timer_regs.vh
// register offsets, field positions and reset values of the period timer
// assumes a 32-bit axi4-lite slave, one aligned word per register
`ifndef PERIOD_TIMER_REGS_VH
`define PERIOD_TIMER_REGS_VH

`define ADDR_COUNT        8'h00
`define ADDR_PERIOD       8'h04
`define ADDR_CONTROL      8'h08
`define ADDR_LIMIT        8'h0c
`define ADDR_CLKSEL       8'h10
`define ADDR_RSTSEL       8'h14
`define ADDR_STATUS       8'h18

`define RST_COUNT         8'h00
`define RST_PERIOD        8'hff
`define RST_CONTROL       8'h00
`define RST_LIMIT         8'h00
`define RST_CLKSEL        5'h00
`define RST_RSTSEL        5'h00

// control: on bit 7, prescale 6:4, postscale 3:0
`define CTL_ON            7
`define CTL_PRE_HI        6
`define CTL_PRE_LO        4
`define CTL_POST_HI       3
`define CTL_POST_LO       0
// limit: mode 4:0
`define LIM_MODE_HI       4
`define LIM_MODE_LO       0
// status: flag bit 0, write one to clear
`define STS_FLAG          0

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// file: period_timer_with_limit.v
// 8-bit period timer with prescaler, postscaler and hardware limit modes
// assumes clock sources and reset sources arrive as asynchronous levels;
// each is synchronised; rising edges of the selected clock source form the timer clock enable
//
// Contract
// - count and period registers readable and writable
// - prescaler divides 1:1 to 1:128
// - postscaler counts period matches, 1:1 to 1:16
// - source codes 0..2: pin, instruction clock, oscillator
// - codes 3..8 oscillators, 16..23 logic cells
// - free-running, one-shot and monostable modes
// - count increments on prescaler output edge
// - match signals postscaler, clears count at next prescaler output
// - gate modes hold count while gate inactive
// - reset modes clear count on level/edge
// - device reset: count zero, period ff
// - scalers cleared on count/control write, reset
// - control write keeps count value
// - free-running: match resets count, advances postscaler
// - postscaler match gives one-tick pulse, clears
// - one-shot clears enable and stops at match
// - one-shot ignores postscaler select
// - monostable stops, keeps enable, restarts on reset
// - postscaled pulse offered to other peripherals
// - period match supplied to pwm logic
// - one external reset source per instance
// - flag set at postscaler match, software clears
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "period_timer_regs.vh"

module period_timer_with_limit (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // clock sources
    input  wire        input_pin_selector,
    input  wire        instruction_clock,
    input  wire        system_osc,
    input  wire        high_freq_internal_osc,
    input  wire        low_freq_internal_osc,
    input  wire        mid_freq_internal_osc,
    input  wire        secondary_osc,
    input  wire        reference_clock_out,
    input  wire        zero_cross_out,
    input  wire [7:0]  logic_cell_out,
    // external reset sources, indexed by reset_source_select
    input  wire [31:0] reset_sources,
    // outputs to peripherals
    output reg         postscaled_pulse,
    output reg         period_match,
    output reg         timer_irq_flag
);

    reg  [7:0]  count_register;
    reg  [7:0]  period_register;
    reg  [7:0]  control_register;
    reg  [7:0]  limit_timer_control;
    reg  [4:0]  clock_source_select;
    reg  [4:0]  reset_source_select;
    reg  [6:0]  pre_count;
    reg  [3:0]  post_count;
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg  [17:0] clk_sync1;
    reg  [17:0] clk_sync2;
    reg  [31:0] ers_sync1;
    reg  [31:0] ers_sync2;
    reg         ers_prev;
    reg         clk_prev;
    reg         ers_prev_valid;

    wire [4:0] mode     = limit_timer_control[`LIM_MODE_HI:`LIM_MODE_LO];
    wire [2:0] pre_sel  = control_register[`CTL_PRE_HI:`CTL_PRE_LO];
    wire [3:0] post_sel = control_register[`CTL_POST_HI:`CTL_POST_LO];
    wire       timer_on = control_register[`CTL_ON];

    // mode field: [4:3] 00 free, 01 one-shot, 10 monostable; [2:0] control
    localparam [1:0] MAJ_FREE = 2'b00;
    localparam [1:0] MAJ_ONE  = 2'b01;
    localparam [1:0] MAJ_MONO = 2'b10;

    // clock source selection, synchronised first
    wire [17:0] clk_raw = {logic_cell_out, 1'b0, zero_cross_out, reference_clock_out,
                           secondary_osc, mid_freq_internal_osc, low_freq_internal_osc,
                           high_freq_internal_osc, system_osc, instruction_clock,
                           input_pin_selector};
    reg clk_sel;
    always @* begin
        if (clock_source_select <= 5'h08)
            clk_sel = clk_sync2[clock_source_select[3:0]];
        else if (clock_source_select[4:3] == 2'b10)
            clk_sel = clk_sync2[5'h0a + {2'b00, clock_source_select[2:0]}];
        else
            clk_sel = 1'b0;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            clk_sync1 <= 18'h00000;
            clk_sync2 <= 18'h00000;
            ers_sync1 <= 32'h00000000;
            ers_sync2 <= 32'h00000000;
            clk_prev  <= 1'b0;
            ers_prev  <= 1'b0;
            ers_prev_valid <= 1'b0;
        end else begin
            clk_sync1 <= clk_raw;
            clk_sync2 <= clk_sync1;
            ers_sync1 <= reset_sources;
            ers_sync2 <= ers_sync1;
            clk_prev  <= clk_sel;
            ers_prev  <= ers_sync2[reset_source_select];
            ers_prev_valid <= 1'b1;
        end
    end

    // one timer clock tick per rising edge of the selected source
    wire tick = clk_sel & ~clk_prev;
    wire ers  = ers_sync2[reset_source_select];
    wire ers_rise = ers_prev_valid & ers & ~ers_prev;
    wire ers_fall = ers_prev_valid & ~ers & ers_prev;

    // gate and reset decode per mode control
    reg run_gate;
    reg ext_reset;
    always @* begin
        run_gate  = timer_on;
        ext_reset = 1'b0;
        case (mode[2:0])
            3'b001: run_gate = timer_on & ers;
            3'b010: run_gate = timer_on & ~ers;
            3'b011: ext_reset = ers_rise | ers_fall;
            3'b100: ext_reset = ers_rise;
            3'b101: ext_reset = ers_fall;
            3'b110: ext_reset = ~ers;
            3'b111: ext_reset = ers;
            default: run_gate = timer_on;
        endcase
    end

    // monostable: stopped after match until an external reset
    reg mono_done;
    wire counting = run_gate & ~(mode[4:3] == MAJ_MONO && mono_done);

    // prescaler terminal count: 2^pre_sel ticks
    wire [6:0] pre_limit = (7'h01 << pre_sel) - 7'h01;
    wire       pre_out   = tick & counting & (pre_count == pre_limit);
    wire       match     = count_register == period_register;
    wire [3:0] post_eff  = (mode[4:3] == MAJ_ONE) ? 4'h0 : post_sel;
    wire       post_hit  = pre_out & match & (post_count == post_eff);

    // bus handshake
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire aw_ok   = aw_held | s_axi_awvalid;
    wire w_ok    = w_held | s_axi_wvalid;
    wire do_wr   = aw_ok & w_ok & ~s_axi_bvalid;
    wire [7:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wd = w_held ? w_data : s_axi_wdata;
    wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
    wire wr_lane = ws[0];
    wire wr_count  = do_wr & wr_lane & (wa == `ADDR_COUNT);
    wire wr_period = do_wr & wr_lane & (wa == `ADDR_PERIOD);
    wire wr_ctl    = do_wr & wr_lane & (wa == `ADDR_CONTROL);
    wire wr_lim    = do_wr & wr_lane & (wa == `ADDR_LIMIT);
    wire wr_clk    = do_wr & wr_lane & (wa == `ADDR_CLKSEL);
    wire wr_rst    = do_wr & wr_lane & (wa == `ADDR_RSTSEL);
    wire wr_sts    = do_wr & wr_lane & (wa == `ADDR_STATUS);
    wire wa_known  = (wa[1:0] == 2'b00) && (wa <= `ADDR_STATUS);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (do_wr) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wa_known ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                if (s_axi_awvalid & s_axi_awready) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (s_axi_wvalid & s_axi_wready) begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
                if (s_axi_bvalid & s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read path
    reg [31:0] rd_word;
    reg        rd_known;
    always @* begin
        rd_known = 1'b1;
        case (s_axi_araddr)
            `ADDR_COUNT:   rd_word = {24'h000000, count_register};
            `ADDR_PERIOD:  rd_word = {24'h000000, period_register};
            `ADDR_CONTROL: rd_word = {24'h000000, control_register};
            `ADDR_LIMIT:   rd_word = {24'h000000, limit_timer_control};
            `ADDR_CLKSEL:  rd_word = {27'h0000000, clock_source_select};
            `ADDR_RSTSEL:  rd_word = {27'h0000000, reset_source_select};
            `ADDR_STATUS:  rd_word = {31'h00000000, timer_irq_flag};
            default: begin
                rd_word  = 32'h00000000;
                rd_known = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // configuration registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            limit_timer_control <= `RST_LIMIT;
            clock_source_select <= `RST_CLKSEL;
            reset_source_select <= `RST_RSTSEL;
            period_register     <= `RST_PERIOD;
        end else begin
            if (wr_lim)
                limit_timer_control <= {3'b000, wd[4:0]};
            if (wr_clk)
                clock_source_select <= wd[4:0];
            if (wr_rst)
                reset_source_select <= wd[4:0];
            if (wr_period)
                period_register <= wd[7:0];
        end
    end

    // counting core
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_register   <= `RST_COUNT;
            control_register <= `RST_CONTROL;
            pre_count        <= 7'h00;
            post_count       <= 4'h0;
            postscaled_pulse <= 1'b0;
            period_match     <= 1'b0;
            mono_done        <= 1'b0;
            timer_irq_flag   <= 1'b0;
        end else begin
            // pulses last exactly one timer clock: until the next tick
            if (tick)
                postscaled_pulse <= 1'b0;
            if (tick)
                period_match <= 1'b0;
            if (wr_ctl) begin
                control_register <= wd[7:0];
                pre_count  <= 7'h00;
                post_count <= 4'h0;
                if (!timer_on && wd[`CTL_ON])
                    mono_done <= 1'b0;
            end else if (wr_count) begin
                count_register <= wd[7:0];
                pre_count  <= 7'h00;
                post_count <= 4'h0;
            end else if (ext_reset && timer_on) begin
                count_register <= 8'h00;
                pre_count  <= 7'h00;
                post_count <= 4'h0;
                mono_done  <= 1'b0;
            end else if (tick && counting) begin
                if (pre_out) begin
                    pre_count <= 7'h00;
                    if (match) begin
                        count_register <= 8'h00;
                        period_match   <= 1'b1;
                        post_count <= post_hit ? 4'h0 : post_count + 4'h1;
                        if (post_hit)
                            postscaled_pulse <= 1'b1;
                        if (mode[4:3] == MAJ_ONE)
                            control_register[`CTL_ON] <= 1'b0;
                        if (mode[4:3] == MAJ_MONO)
                            mono_done <= 1'b1;
                    end else begin
                        count_register <= count_register + 8'h01;
                    end
                end else begin
                    pre_count <= pre_count + 7'h01;
                end
            end
            // set wins over the software clear
            if (post_hit && tick && counting && !wr_ctl && !wr_count
                && !(ext_reset && timer_on))
                timer_irq_flag <= 1'b1;
            else if (wr_sts && wd[`STS_FLAG])
                timer_irq_flag <= 1'b0;
        end
    end

endmodule // period_timer_with_limit

// file: tb_top.sv
// testbench for period_timer_with_limit: register tasks over axi4-lite
// assumes the source model gives one timer tick per four aclk
`timescale 1ns/10ps
`include "period_timer_regs.vh"
module tb_top;
    localparam int PER = 3;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, reset_sources = 32'h0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, flood = 0;
    logic [4:0]  sel = 5'h00;
    logic [8:0]  src;
    logic [7:0]  cells;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         postscaled_pulse, period_match, timer_irq_flag;
    int          fail_count = 0, comparisons = 0;
    int          pre_v [4] = '{0, 2, 7, 0};
    int          post_v [4] = '{0, 1, 0, 15};
    logic [31:0] rst_v [7] = '{`RST_COUNT, `RST_PERIOD, `RST_CONTROL, `RST_LIMIT,
                                `RST_CLKSEL, `RST_RSTSEL, 32'h0};

    period_timer_with_limit u_period_timer_with_limit (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .input_pin_selector(src[0]), .instruction_clock(src[1]),
        .system_osc(src[2]), .high_freq_internal_osc(src[3]), .low_freq_internal_osc(src[4]),
        .mid_freq_internal_osc(src[5]), .secondary_osc(src[6]), .reference_clock_out(src[7]),
        .zero_cross_out(src[8]), .logic_cell_out(cells), .reset_sources, .postscaled_pulse,
        .period_match, .timer_irq_flag);
    timer_sources_model u_timer_sources_model (.aclk, .sel, .flood, .src, .cells);

    initial forever #20 aclk = ~aclk;

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bound_out(input int n);
        if (n == 60) begin
            fail_count++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (s_axi_bvalid === 1'b1) break;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk("write resp", {30'h0, er}, {30'h0, s_axi_bresp});
        bound_out(n);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (s_axi_rvalid === 1'b1) break;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk("read data", ed, s_axi_rdata);
        chk("read resp", {30'h0, er}, {30'h0, s_axi_rresp});
        bound_out(n);
    endtask
    // cycles until the next rising edge of the match or pulse output, 0 if none
    task automatic rise(input bit which, input int bound, output int at);
        logic p, s;
        p = 1'b1;
        at = 0;
        for (int n = 1; n <= bound && at == 0; n++) begin
            @(posedge aclk);
            s = which ? postscaled_pulse : period_match;
            if (s === 1'b1 && p !== 1'b1) at = n;
            p = s;
        end
    endtask

    initial begin
        int t, g;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rst_v[i]) rd(8'(4 * i), rst_v[i], `RESP_OKAY);
        rd(8'h1c, 32'h0, `RESP_SLVERR);
        rd(8'h05, 32'h0, `RESP_SLVERR);
        wr(8'h1c, 32'h1, `RESP_SLVERR);
        wr(`ADDR_PERIOD, 32'h1234_5603, `RESP_OKAY);
        rd(`ADDR_PERIOD, PER, `RESP_OKAY);
        wr(`ADDR_COUNT, 32'h05, `RESP_OKAY);
        wr(`ADDR_CONTROL, 32'h00, `RESP_OKAY);
        rd(`ADDR_COUNT, 32'h05, `RESP_OKAY);
        wr(`ADDR_COUNT, 32'h00, `RESP_OKAY);
        for (int c = 0; c < 25; c++) if (c < 9 || c > 15) begin
            sel <= 5'(c);
            flood <= (c > 23);
            wr(`ADDR_CLKSEL, c, `RESP_OKAY);
            wr(`ADDR_CONTROL, 32'h80, `RESP_OKAY);
            rise(0, 100, t);
            rise(0, 100, g);
            chk("match gap", (c > 23) ? 0 : 4 * (PER + 1), g);
        end
        flood <= 1'b0;
        sel <= 5'h01;
        wr(`ADDR_CLKSEL, 32'h01, `RESP_OKAY);
        foreach (pre_v[i]) begin
            wr(`ADDR_CONTROL, 128 + pre_v[i] * 16 + post_v[i], `RESP_OKAY);
            rise(0, 5000, t);
            rise(0, 5000, g);
            chk("match gap", (4 * (PER + 1)) << pre_v[i], g);
            rise(1, 9000, t);
            rise(1, 9000, g);
            chk("pulse gap", ((4 * (PER + 1)) << pre_v[i]) * (post_v[i] + 1), g);
        end
        rd(`ADDR_STATUS, 32'h1, `RESP_OKAY);
        wr(`ADDR_CONTROL, 32'h00, `RESP_OKAY);
        wr(`ADDR_STATUS, 32'h1, `RESP_OKAY);
        rd(`ADDR_STATUS, 32'h0, `RESP_OKAY);
        wr(`ADDR_LIMIT, 32'h08, `RESP_OKAY);
        wr(`ADDR_COUNT, 32'h00, `RESP_OKAY);
        wr(`ADDR_CONTROL, 32'h83, `RESP_OKAY);
        rise(1, 200, t);
        chk("one-shot pulse", 1, t != 0);
        rd(`ADDR_CONTROL, 32'h03, `RESP_OKAY);
        rise(0, 200, t);
        chk("one-shot stopped", 0, t);
        wr(`ADDR_CONTROL, 32'h00, `RESP_OKAY);
        wr(`ADDR_CONTROL, 32'h83, `RESP_OKAY);
        rise(0, 200, t);
        chk("one-shot restart", 1, t != 0);
        wr(`ADDR_RSTSEL, 32'h02, `RESP_OKAY);
        wr(`ADDR_LIMIT, 32'h14, `RESP_OKAY);
        wr(`ADDR_COUNT, 32'h00, `RESP_OKAY);
        wr(`ADDR_CONTROL, 32'h80, `RESP_OKAY);
        rise(0, 200, t);
        rise(0, 200, t);
        chk("mono stopped", 0, t);
        rd(`ADDR_CONTROL, 32'h80, `RESP_OKAY);
        reset_sources[2] <= 1'b1;
        rise(0, 200, t);
        chk("mono restart", 1, t != 0);
        reset_sources[2] <= 1'b0;
        wr(`ADDR_LIMIT, 32'h01, `RESP_OKAY);
        wr(`ADDR_COUNT, 32'h00, `RESP_OKAY);
        rise(0, 200, t);
        chk("gated off", 0, t);
        rd(`ADDR_COUNT, 32'h00, `RESP_OKAY);
        reset_sources[2] <= 1'b1;
        rise(0, 200, t);
        chk("gated on", 1, t != 0);
        wr(`ADDR_LIMIT, 32'h07, `RESP_OKAY);
        rise(0, 200, t);
        chk("held in reset", 0, t);
        rd(`ADDR_COUNT, 32'h00, `RESP_OKAY);
        wr(`ADDR_LIMIT, 32'h06, `RESP_OKAY);
        rise(0, 200, t);
        chk("low reset idle", 1, t != 0);
        wr(`ADDR_LIMIT, 32'h02, `RESP_OKAY);
        rise(0, 200, t);
        chk("gate low off", 0, t);
        reset_sources[2] <= 1'b0;
        rise(0, 200, t);
        chk("gate low on", 1, t != 0);
        wr(`ADDR_LIMIT, 32'h06, `RESP_OKAY);
        rise(0, 200, t);
        chk("low reset held", 0, t);
        wr(`ADDR_LIMIT, 32'h15, `RESP_OKAY);
        rise(0, 200, t);
        rise(0, 200, t);
        chk("mono fall stopped", 0, t);
        reset_sources[2] <= 1'b1;
        rise(0, 200, t);
        chk("rise ignored", 0, t);
        reset_sources[2] <= 1'b0;
        rise(0, 200, t);
        chk("fall restart", 1, t != 0);
        wr(`ADDR_LIMIT, 32'h13, `RESP_OKAY);
        rise(0, 200, t);
        chk("both edge stopped", 0, t);
        reset_sources[2] <= 1'b1;
        rise(0, 200, t);
        chk("both edge restart", 1, t != 0);
        summarize();
    end
endmodule // tb_top

// file: timer_sources_model.sv
// clock source model: the selected source runs as a slow square wave
// assumes sel follows the code written to the clock select register
`timescale 1ns/10ps
module timer_sources_model (
    // clock
    input  wire        aclk,
    // selection and fault injection
    input  wire [4:0]  sel,
    input  wire        flood,
    // source levels
    output logic [8:0] src,
    output logic [7:0] cells
);
    logic [1:0] phase = 2'h0;
    always @(posedge aclk) phase <= phase + 2'h1;
    // two aclk high, two low; flood drives every source at once
    always_comb begin
        src = 9'h000;
        cells = 8'h00;
        if (flood) begin
            src = {9{phase[1]}};
            cells = {8{phase[1]}};
        end else if (sel < 5'h09) src[sel[3:0]] = phase[1];
        else if (sel[4:3] == 2'b10) cells[sel[2:0]] = phase[1];
    end
endmodule // timer_sources_model
